// file: logic/mrx_regs.sv
// Receive-drop counter, RMII support and station address registers behind APB
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "mrx_consts.svh"
`default_nettype none

// Functional notes
// - Each filter-accepted frame dropped by receive FIFO overrun adds one to the 16-bit count.
// - Each such drop also sets the receive overflow interrupt flag, bit 0 of the flag register.
// - A read of the count clears it only when both low byte strobes of the read are on.
// - While the RMII reset bit 11 is one the RMII logic is held in reset.
// - RMII speed bit 8 selects 100 Mbps when set and 10 Mbps when clear.
// - RMII reset and speed bits act only when the reduced interface is in use.
// - 16-bit and 32-bit accesses, aliases included, are accepted; 8-bit ones change nothing.
// - Station register bits 15 to 8 hold the sixth station address octet.
// - Station register bits 7 to 0 hold the fifth station address octet.
// - The station register loads the factory address at reset and is writable afterwards.
// - Unimplemented bits, 31 to 16 included, read as zero.
module mrx_regs
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_overrun_drop,
  input  wire logic        rmii_mode,
  input  wire logic [15:0] factory_station,
  output logic             rmii_logic_reset,
  output logic             rmii_speed_100,
  output logic [7:0]       station_octet_six,
  output logic [7:0]       station_octet_five,
  output logic             irq
);
  import mrx_pkg::*;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  mrx_wr_if wr ();

  logic        acc;
  logic        size_ok;
  logic        mapped;
  logic        wr_go;
  logic        rd_go;
  logic [11:0] base;
  logic [15:0] next_drop;
  logic        drop_ev;
  logic        next_rmii_reset;
  logic        next_rmii_speed;
  logic        drop_rd_clear;
  logic [2:0]  strobe_cnt;

  mrx_half_t   drop_count;
  mrx_half_t   supp;
  mrx_half_t   station;
  logic        irq_stat;
  logic        irq_en;
  logic [1:0]  drop_sync;
  logic        mode_meta;
  logic        mode_sync;

  assign acc = psel && penable && !pready;
  assign base = {paddr[11:4], 4'h0};
  assign strobe_cnt = 3'(pstrb[0]) + 3'(pstrb[1]) + 3'(pstrb[2]) + 3'(pstrb[3]);
  assign size_ok = !pwrite || (pstrb == 4'h3) || (pstrb == 4'hc) || (pstrb == 4'hf);
  assign mapped = (base == `MRX_OFS_DROP) || (base == `MRX_OFS_SUPP)
                  || (base == `MRX_OFS_STATION) || (paddr == `MRX_OFS_IRQ_STAT)
                  || (paddr == `MRX_OFS_IRQ_EN) || (paddr == `MRX_OFS_IRQ_CLR);
  assign wr_go = acc && pwrite && size_ok && mapped && (strobe_cnt != 3'h1);
  assign rd_go = acc && !pwrite && mapped;

  mrx_apb_dec u_dec
  (
    .paddr  (paddr),
    .wr_go  (wr_go),
    .pwdata (pwdata),
    .wr     (wr)
  );

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc && !mapped;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata <= 32'h0;
    end
    else if (rd_go && (paddr[3:2] == `MRX_ALIAS_PLAIN || paddr == `MRX_OFS_IRQ_EN))
    begin
      case (base)
        `MRX_OFS_DROP:    prdata <= {16'h0, drop_count};
        `MRX_OFS_SUPP:    prdata <= {16'h0, supp & `MRX_SUPP_MASK};
        `MRX_OFS_STATION: prdata <= {16'h0, station};
        default:
        begin
          if (paddr == `MRX_OFS_IRQ_STAT)
            prdata <= {31'h0, irq_stat};
          else if (paddr == `MRX_OFS_IRQ_EN)
            prdata <= {31'h0, irq_en};
          else
            prdata <= 32'h0;
        end
      endcase
    end
    else
    begin
      prdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Drop event input
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      drop_sync <= 2'h0;
    else
      drop_sync <= {drop_sync[0], rx_overrun_drop};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
    end
    else
    begin
      mode_meta <= rmii_mode;
      mode_sync <= mode_meta;
    end
  end

  assign drop_ev = drop_sync[1];
  assign drop_rd_clear = rd_go && base == `MRX_OFS_DROP
                         && paddr[3:2] == `MRX_ALIAS_PLAIN
                         && (pstrb == 4'h3 || pstrb == 4'hf);

  // ----------------------------------------------------------------
  // Dropped frame count
  // ----------------------------------------------------------------
  always_comb
  begin
    next_drop = drop_count;
    if (wr.en && wr.is_drop)
    begin
      case (wr.alias_sel)
        MRX_ALIAS_WR_PLAIN: next_drop = wr.data;
        MRX_ALIAS_WR_CLR:   next_drop = drop_count & ~wr.data;
        MRX_ALIAS_WR_SET:   next_drop = drop_count | wr.data;
        MRX_ALIAS_WR_INV:   next_drop = drop_count ^ wr.data;
        default:            next_drop = drop_count;
      endcase
    end
    else if (drop_rd_clear)
      next_drop = 16'h0;
    if (drop_ev)
      next_drop = next_drop + 16'h1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      drop_count <= `MRX_DROP_RESET;
    else
      drop_count <= next_drop;
  end

  // ----------------------------------------------------------------
  // RMII support register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      supp <= `MRX_SUPP_RESET;
    else if (wr.en && wr.is_supp)
    begin
      case (wr.alias_sel)
        MRX_ALIAS_WR_PLAIN: supp <= wr.data & `MRX_SUPP_MASK;
        MRX_ALIAS_WR_CLR:   supp <= supp & ~wr.data;
        MRX_ALIAS_WR_SET:   supp <= (supp | wr.data) & `MRX_SUPP_MASK;
        MRX_ALIAS_WR_INV:   supp <= (supp ^ wr.data) & `MRX_SUPP_MASK;
        default:            supp <= supp;
      endcase
    end
  end

  // Controls reach the RMII logic only in reduced interface mode
  assign next_rmii_reset = mode_sync && supp[`MRX_SUPP_RESET_BIT];
  assign next_rmii_speed = mode_sync && supp[`MRX_SUPP_SPEED_BIT];

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rmii_logic_reset <= 1'b0;
      rmii_speed_100   <= 1'b0;
    end
    else
    begin
      rmii_logic_reset <= next_rmii_reset;
      rmii_speed_100   <= next_rmii_speed;
    end
  end

  // ----------------------------------------------------------------
  // Station address octets
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      station <= factory_station;
    else if (wr.en && wr.is_station)
    begin
      case (wr.alias_sel)
        MRX_ALIAS_WR_PLAIN: station <= wr.data;
        MRX_ALIAS_WR_CLR:   station <= station & ~wr.data;
        MRX_ALIAS_WR_SET:   station <= station | wr.data;
        MRX_ALIAS_WR_INV:   station <= station ^ wr.data;
        default:            station <= station;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      station_octet_six  <= factory_station[15:8];
      station_octet_five <= factory_station[7:0];
    end
    else
    begin
      station_octet_six  <= station[15:8];
      station_octet_five <= station[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flag, enable and clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_stat <= `MRX_IRQ_RESET;
    else if (drop_ev)
      irq_stat <= 1'b1;
    else if (wr.en && wr.is_irq_clr && wr.data[`MRX_IRQ_OVF_BIT])
      irq_stat <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      irq_en <= 1'b0;
    else if (wr.en && wr.is_irq_en)
      irq_en <= wr.data[`MRX_IRQ_OVF_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= irq_stat && irq_en;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_drop_count_inc: assert property (@(posedge clk) disable iff (srst)
    drop_ev && !(wr.en && wr.is_drop) && !drop_rd_clear
    |=> drop_count == $past(drop_count) + 16'h1)
    else $error("drop count did not advance");

  a_drop_sets_flag: assert property (@(posedge clk) disable iff (srst)
    drop_ev |=> irq_stat)
    else $error("overflow flag not set by drop");

  a_read_clears: assert property (@(posedge clk) disable iff (srst)
    drop_rd_clear && !drop_ev && !(wr.en && wr.is_drop) |=> drop_count == 16'h0)
    else $error("count not cleared by read");

  a_rmii_reset_out: assert property (@(posedge clk) disable iff (srst)
    mode_sync && supp[`MRX_SUPP_RESET_BIT] |=> rmii_logic_reset)
    else $error("rmii reset not applied");

  a_rmii_speed_out: assert property (@(posedge clk) disable iff (srst)
    ##1 rmii_speed_100 == $past(mode_sync && supp[`MRX_SUPP_SPEED_BIT]))
    else $error("rmii speed mismatch");

  a_rmii_unused: assert property (@(posedge clk) disable iff (srst)
    !mode_sync |=> !rmii_logic_reset && !rmii_speed_100)
    else $error("rmii controls active outside rmii mode");

  a_byte_write_ign: assert property (@(posedge clk) disable iff (srst)
    acc && pwrite && strobe_cnt == 3'h1 && base == `MRX_OFS_STATION
    |=> $stable(station))
    else $error("byte write changed state");

  a_station_octets: assert property (@(posedge clk) disable iff (srst)
    ##1 {station_octet_six, station_octet_five} == $past(station))
    else $error("station octets mismatch");

  a_upper_zero: assert property (@(posedge clk) disable iff (srst)
    pready |-> prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");

  a_count_wraps: assert property (@(posedge clk) disable iff (srst)
    drop_ev && drop_count == 16'hffff && !(wr.en && wr.is_drop) |=> drop_count == 16'h0)
    else $error("count did not wrap");

endmodule
`default_nettype wire

// file: logic/mrx_consts.svh
// Register offsets, field positions and reset values of the receive-drop/RMII/station block
`ifndef MRX_CONSTS_SVH
`define MRX_CONSTS_SVH

// Base offsets of the three registers (each a 16-byte group: plain, clear, set, invert) and of the three interrupt registers
`define MRX_OFS_DROP      12'h000
`define MRX_OFS_SUPP      12'h010
`define MRX_OFS_STATION   12'h020
`define MRX_OFS_IRQ_STAT  12'h030
`define MRX_OFS_IRQ_EN    12'h034
`define MRX_OFS_IRQ_CLR   12'h038

// Alias selector in address bits 3:2
`define MRX_ALIAS_PLAIN   2'h0
`define MRX_ALIAS_CLR     2'h1
`define MRX_ALIAS_SET     2'h2
`define MRX_ALIAS_INV     2'h3

// Field positions
`define MRX_SUPP_RESET_BIT 11
`define MRX_SUPP_SPEED_BIT 8
`define MRX_IRQ_OVF_BIT    0

// Reset values
`define MRX_DROP_RESET    16'h0000
`define MRX_SUPP_RESET    16'h0000
`define MRX_IRQ_RESET     1'h0

// Writable masks
`define MRX_SUPP_MASK     16'h0900
`define MRX_FULL_MASK     16'hffff

`endif

// file: logic/mrx_pkg.sv
// Types shared by the receive-drop/RMII/station block
package mrx_pkg;
  typedef enum logic [1:0] {
    MRX_ALIAS_WR_PLAIN,
    MRX_ALIAS_WR_CLR,
    MRX_ALIAS_WR_SET,
    MRX_ALIAS_WR_INV
  } mrx_alias_e;

  typedef logic [15:0] mrx_half_t;
endpackage

// file: logic/mrx_wr_if.sv
// Decoded register write carried from the bus decoder to the register file
`timescale 1ns/100ps
`default_nettype none
interface mrx_wr_if;
  logic              en;
  logic              is_drop;
  logic              is_supp;
  logic              is_station;
  logic              is_irq_en;
  logic              is_irq_clr;
  mrx_pkg::mrx_alias_e alias_sel;
  logic [15:0]       data;

  modport dec
  (
    output en,
    output is_drop,
    output is_supp,
    output is_station,
    output is_irq_en,
    output is_irq_clr,
    output alias_sel,
    output data
  );
  modport regs
  (
    input en,
    input is_drop,
    input is_supp,
    input is_station,
    input is_irq_en,
    input is_irq_clr,
    input alias_sel,
    input data
  );
endinterface
`default_nettype wire

// file: logic/mrx_apb_dec.sv
// Combinational APB write decoder for the receive-drop/RMII/station block
`timescale 1ns/100ps
`include "mrx_consts.svh"
`default_nettype none
module mrx_apb_dec
(
  input  wire logic [11:0] paddr,
  input  wire logic        wr_go,
  input  wire logic [31:0] pwdata,
  mrx_wr_if.dec            wr
);
  import mrx_pkg::*;

  logic [11:0] base;

  assign base          = {paddr[11:4], 4'h0};
  assign wr.en         = wr_go;
  assign wr.is_drop    = (base == `MRX_OFS_DROP);
  assign wr.is_supp    = (base == `MRX_OFS_SUPP);
  assign wr.is_station = (base == `MRX_OFS_STATION);
  assign wr.is_irq_en  = (paddr == `MRX_OFS_IRQ_EN);
  assign wr.is_irq_clr = (paddr == `MRX_OFS_IRQ_CLR);
  assign wr.alias_sel  = mrx_alias_e'(paddr[3:2]);
  assign wr.data       = pwdata[15:0];
endmodule
`default_nettype wire

// file: tb/mrx_rx_side_model.sv
// Model of the receive path and PHY side that feeds the register block
`timescale 1ns/100ps
`default_nettype none
module mrx_rx_side_model
(
  input  wire logic clk,
  output logic      rx_overrun_drop,
  output logic      rmii_mode
);
  initial
  begin
    rx_overrun_drop = 1'b0;
    rmii_mode       = 1'b0;
  end

  // Dropped frames: one-cycle pulses with a low cycle between them
  task automatic drop(input int n);
    repeat (n)
    begin
      @(posedge clk);
      rx_overrun_drop <= 1'b1;
      @(posedge clk);
      rx_overrun_drop <= 1'b0;
    end
    repeat (6) @(posedge clk);
  endtask

  // Reduced interface selection, settled before it returns
  task automatic mode(input logic m);
    @(posedge clk);
    rmii_mode <= m;
    repeat (5) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/mac_rx_drop_rmii_station_regs_tb.sv
// Register tests of the receive-drop/RMII/station block over APB
`timescale 1ns/100ps
`default_nettype none
module mac_rx_drop_rmii_station_regs_tb;
  localparam logic [15:0] FACTORY = 16'h3c5a;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, drop, mode;
  logic rst_o, spd_o, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  pstrb;
  logic [7:0]  oct6, oct5;
  int errors, comparisons, cycles;

  mrx_regs i_dut
  (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_overrun_drop(drop),
    .rmii_mode(mode), .factory_station(FACTORY), .rmii_logic_reset(rst_o),
    .rmii_speed_100(spd_o), .station_octet_six(oct6),
    .station_octet_five(oct5), .irq(irq)
  );
  mrx_rx_side_model i_far
  (
    .clk(clk), .rx_overrun_drop(drop), .rmii_mode(mode)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; waits for pready and captures the answer at that edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    chk("pslverr", {31'h0, pslverr}, {31'h0, a >= 12'h03c});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    bus(1'b1, a, d, s);
  endtask

  task automatic rd(input logic [11:0] a, input logic [3:0] s, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, s);
    chk("read data", rdata, exp);
  endtask

  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(12'h000, 4'hf, 32'h0);
    rd(12'h010, 4'hf, 32'h0);
    rd(12'h020, 4'hf, {16'h0, FACTORY});
    chk("octets", {oct6, oct5}, FACTORY);
    // Three drops, flag raises the interrupt, count clears on read
    wr(12'h034, 32'h1, 4'hf);
    rd(12'h034, 4'hf, 32'h1);
    i_far.drop(3);
    chk("irq", irq, 1'b1);
    rd(12'h030, 4'hf, 32'h1);
    rd(12'h000, 4'hf, 32'h3);
    rd(12'h000, 4'hf, 32'h0);
    wr(12'h038, 32'h1, 4'hf);
    @(negedge clk);
    chk("irq", irq, 1'b0);
    // Read without both low byte enables on keeps the count; a 16-bit low read clears it
    i_far.drop(1);
    rd(12'h000, 4'h0, 32'h1);
    rd(12'h000, 4'h1, 32'h1);
    rd(12'h000, 4'hc, 32'h1);
    rd(12'h000, 4'h3, 32'h1);
    rd(12'h000, 4'hf, 32'h0);
    wr(12'h034, 32'h0, 4'hf);
    @(negedge clk);
    chk("irq", irq, 1'b0);
    wr(12'h038, 32'h1, 4'hf);
    rd(12'h030, 4'hf, 32'h0);
    // Debug preload then wrap
    wr(12'h008, 32'hffff, 4'hf);
    i_far.drop(1);
    rd(12'h000, 4'hf, 32'h0);
    // Support bits through aliases; 8-bit write ignored
    i_far.mode(1'b1);
    wr(12'h010, 32'hffffffff, 4'h1);
    rd(12'h010, 4'hf, 32'h0);
    wr(12'h018, 32'hffffffff, 4'h3);
    rd(12'h010, 4'hf, 32'h900);
    chk("rmii ctl", {rst_o, spd_o}, 2'b11);
    wr(12'h014, 32'h100, 4'hf);
    rd(12'h010, 4'hf, 32'h800);
    chk("rmii ctl", {rst_o, spd_o}, 2'b10);
    wr(12'h01c, 32'h900, 4'hf);
    rd(12'h010, 4'hf, 32'h100);
    chk("rmii ctl", {rst_o, spd_o}, 2'b01);
    i_far.mode(1'b0);
    chk("rmii ctl", {rst_o, spd_o}, 2'b00);
    // Station address overwrite, 16-bit access
    wr(12'h020, 32'h0000a55a, 4'hc);
    rd(12'h020, 4'hf, 32'ha55a);
    chk("octet six", oct6, 8'ha5);
    chk("octet five", oct5, 8'h5a);
    wr(12'h020, 32'h0000ffff, 4'h2);
    rd(12'h020, 4'hf, 32'ha55a);
    rd(12'h040, 4'hf, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
